// File: rtl/ast_pkg.sv
// Constants, register map and state types of the asynchronous serial transmitter
`default_nettype none

package ast_pkg;

  // Register byte addresses on the APB slave
  localparam logic [7:0] AST_ADDR_CTRL = 8'h00;
  localparam logic [7:0] AST_ADDR_DATA = 8'h04;
  localparam logic [7:0] AST_ADDR_STAT = 8'h08;
  localparam logic [7:0] AST_ADDR_BAUD = 8'h0c;

  // Control register bit positions
  localparam int AST_CTRL_TX_ON = 0;
  localparam int AST_CTRL_SYNC = 1;
  localparam int AST_CTRL_PORT_ON = 2;
  localparam int AST_CTRL_NINE = 3;
  localparam int AST_CTRL_INV = 4;
  localparam int AST_CTRL_BIT9 = 5;
  localparam int AST_CTRL_TX_IRQ = 6;
  localparam int AST_CTRL_PERI_IRQ = 7;
  localparam int AST_CTRL_ALL_IRQ = 8;

  // Status register bit positions
  localparam int AST_STAT_TBEF = 0;
  localparam int AST_STAT_TSEF = 1;
  localparam int AST_STAT_LINE = 2;

  // Baud register layout: divisor in the low half, width select above it
  localparam int AST_BAUD_WIDE = 16;
  localparam int AST_DIV_W = 16;
  localparam logic [AST_DIV_W-1:0] AST_DIV_RESET = 16'h0067;

  // Character lengths and flag settling delay in instruction cycles
  localparam logic [3:0] AST_LAST_BIT_8 = 4'h7;
  localparam logic [3:0] AST_LAST_BIT_9 = 4'h8;
  localparam logic [1:0] AST_FLAG_SETTLE = 2'h2;

  typedef enum logic [1:0] {
    AST_IDLE,
    AST_START,
    AST_DATA,
    AST_STOP
  } ast_phase_t;

  typedef struct packed {
    logic transmit_enable;
    logic clocked_mode_select;
    logic serial_port_enable;
    logic nine_bit_tx_select;
    logic tx_polarity_invert;
    logic ninth_tx_bit;
    logic transmit_irq_enable;
    logic peripheral_irq_enable;
    logic global_irq_enable;
  } ast_ctrl_t;

  localparam ast_ctrl_t AST_CTRL_RESET = '0;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ast_apb_req_t;

endpackage

`default_nettype wire

// File: rtl/ast_tx.sv
// Asynchronous serial transmitter with APB register access
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`default_nettype none

// Overview of operation
// RL1: Start space, 8/9 data, stop mark, idle mark
// RL2: Every bit lasts exactly one bit period
// RL3: Divider of 8 or 16 bits sets rate
// RL4: Data leaves least significant bit first
// RL5: No hardware parity; ninth bit carries it
// RL6: Runs only with enable, async, port on
// RL7: Port enable turns output driver on
// RL8: Idle shifter takes written character at once
// RL9: Busy shifter: pending character loads after stop
// RL10: Reloaded character starts with no gap
// RL11: Polarity bit inverts idle and data levels
// RL12: Buffer empty flag set unless character waits; the code also keeps it clear while the transmitter is stopped
// RL13: Flag settles in second cycle after write
// RL14: Buffer empty flag is read only
// RL15: Interrupt needs flag and three enables
// RL16: Read only shifter empty status, no interrupt
// RL17: Nine bit mode sends ninth bit last
// RL18: Software writes ninth bit before data
// RL19: Software follows documented setup order
// RL20: Software enables interrupt only while sending
// RL21: Disabling aborts character and idles line
// RL22: Bit ticks come from separate rate divider
module ast_tx
  import ast_pkg::*;
#(
  parameter int DIV_WIDTH = AST_DIV_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic tx_out,
  output logic tx_oe,
  output logic irq_req
);

  // Elaboration check on the divider width
  if (DIV_WIDTH != AST_DIV_W) begin : g_bad_width
    $error("ast_tx: DIV_WIDTH must equal the 16-bit divider width");
  end

  // Whole module state in one record
  typedef struct packed {
    ast_ctrl_t ctrl;
    logic [DIV_WIDTH-1:0] divisor;
    logic wide_div;
    logic [DIV_WIDTH-1:0] brg_cnt;
    logic [8:0] hold_data;
    logic hold_full;
    logic [8:0] shift;
    logic nine_latched;
    logic [3:0] bit_cnt;
    ast_phase_t phase;
    logic line;
    logic buf_empty;
    logic [1:0] settle;
    logic shift_empty;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tx_out;
    logic tx_oe;
    logic irq_req;
  } ast_state_t;

  localparam ast_state_t AST_STATE_RESET = '{
    ctrl: AST_CTRL_RESET,
    divisor: AST_DIV_RESET,
    wide_div: 1'b0,
    brg_cnt: '0,
    hold_data: '0,
    hold_full: 1'b0,
    shift: '0,
    nine_latched: 1'b0,
    bit_cnt: '0,
    phase: AST_IDLE,
    line: 1'b1,
    buf_empty: 1'b0,
    settle: '0,
    shift_empty: 1'b1,
    prdata: '0,
    pready: 1'b0,
    pslverr: 1'b0,
    tx_out: 1'b1,
    tx_oe: 1'b0,
    irq_req: 1'b0
  };

  // State register pair and bundled bus request
  ast_state_t s_reg;
  ast_state_t s_next;
  ast_apb_req_t req;

  // Decoded bus phases, run state and rate divider helpers
  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic run;
  logic tick;
  logic last_data;
  logic [DIV_WIDTH-1:0] reload;
  logic [31:0] rd_word;
  logic data_wr;

  // Bundle the bus request
  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // Bus phase decode
  assign setup = req.psel & ~req.penable;
  assign access = req.psel & req.penable & s_reg.pready;
  assign wr = access & req.pwrite & ~s_reg.pslverr;
  assign mapped = (req.paddr == AST_ADDR_CTRL) | (req.paddr == AST_ADDR_DATA) |
                  (req.paddr == AST_ADDR_STAT) | (req.paddr == AST_ADDR_BAUD);

  // Transmitter runs only in async mode with both enables
  assign run = s_reg.ctrl.transmit_enable & ~s_reg.ctrl.clocked_mode_select &
               s_reg.ctrl.serial_port_enable; // [RL6]

  // Accepted character write; ignored while the transmitter is stopped
  assign data_wr = wr & (req.paddr == AST_ADDR_DATA) & run & pstrb[0];

  // Divider reload: narrow mode uses low byte only
  assign reload = s_reg.wide_div ? s_reg.divisor :
                  {{(DIV_WIDTH-8){1'b0}}, s_reg.divisor[7:0]}; // [RL3]

  // One-cycle bit-rate tick from the rate divider
  assign tick = (s_reg.brg_cnt == '0); // [RL22]

  // Last data bit index depends on latched character length
  assign last_data = (s_reg.bit_cnt == (s_reg.nine_latched ? AST_LAST_BIT_9 :
                                                             AST_LAST_BIT_8)); // [RL1]

  // Read data multiplexer
  always_comb begin
    rd_word = '0;
    unique case (req.paddr)
      AST_ADDR_CTRL: begin
        rd_word[AST_CTRL_TX_ON] = s_reg.ctrl.transmit_enable;
        rd_word[AST_CTRL_SYNC] = s_reg.ctrl.clocked_mode_select;
        rd_word[AST_CTRL_PORT_ON] = s_reg.ctrl.serial_port_enable;
        rd_word[AST_CTRL_NINE] = s_reg.ctrl.nine_bit_tx_select;
        rd_word[AST_CTRL_INV] = s_reg.ctrl.tx_polarity_invert;
        rd_word[AST_CTRL_BIT9] = s_reg.ctrl.ninth_tx_bit;
        rd_word[AST_CTRL_TX_IRQ] = s_reg.ctrl.transmit_irq_enable;
        rd_word[AST_CTRL_PERI_IRQ] = s_reg.ctrl.peripheral_irq_enable;
        rd_word[AST_CTRL_ALL_IRQ] = s_reg.ctrl.global_irq_enable;
      end
      AST_ADDR_DATA: begin
        rd_word[8:0] = s_reg.hold_data;
      end
      AST_ADDR_STAT: begin
        rd_word[AST_STAT_TBEF] = s_reg.buf_empty;
        rd_word[AST_STAT_TSEF] = s_reg.shift_empty; // [RL16]
        rd_word[AST_STAT_LINE] = s_reg.tx_out;
      end
      AST_ADDR_BAUD: begin
        rd_word[DIV_WIDTH-1:0] = s_reg.divisor;
        rd_word[AST_BAUD_WIDE] = s_reg.wide_div;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  // Next-state logic: bus slave, character engine, flags, pins
  always_comb begin
    s_next = s_reg;

    // Bus answer: ready one cycle after setup, error for unmapped address
    s_next.pready = setup;
    s_next.pslverr = setup & ~mapped;
    if (setup) begin
      s_next.prdata = rd_word;
    end

    // Rate divider counts down, reloads on tick, held while idle
    if (s_reg.phase == AST_IDLE) begin
      s_next.brg_cnt = reload;
    end else if (tick) begin
      s_next.brg_cnt = reload; // [RL2]
    end else begin
      s_next.brg_cnt = s_reg.brg_cnt - 1'b1;
    end

    // Character engine
    if (!run) begin
      // Disable aborts everything and idles the line
      s_next.hold_full = 1'b0; // [RL21]
      s_next.phase = AST_IDLE;
      s_next.line = 1'b1;
      s_next.bit_cnt = '0;
    end else begin
      unique case (s_reg.phase)
        AST_IDLE: begin
          s_next.line = 1'b1; // [RL1]
          if (s_reg.hold_full) begin
            // Idle shifter takes the pending character immediately
            s_next.shift = s_reg.hold_data; // [RL8]
            s_next.nine_latched = s_reg.ctrl.nine_bit_tx_select;
            s_next.hold_full = 1'b0;
            s_next.phase = AST_START;
            s_next.line = 1'b0; // [RL1]
            s_next.bit_cnt = '0;
          end
        end
        AST_START: begin
          if (tick) begin
            s_next.line = s_reg.shift[0]; // [RL4]
            s_next.shift = {1'b0, s_reg.shift[8:1]};
            s_next.phase = AST_DATA;
          end
        end
        AST_DATA: begin
          if (tick) begin
            s_next.bit_cnt = s_reg.bit_cnt + 1'b1;
            if (last_data) begin
              // Stop bit at mark; no parity bit is appended
              s_next.line = 1'b1; // [RL5]
              s_next.phase = AST_STOP;
            end else begin
              s_next.line = s_reg.shift[0]; // [RL4]
              s_next.shift = {1'b0, s_reg.shift[8:1]};
            end
          end
        end
        AST_STOP: begin
          if (tick) begin
            if (s_reg.hold_full) begin
              // Pending character loads on the stop-bit end, start follows at once
              s_next.shift = s_reg.hold_data; // [RL9]
              s_next.nine_latched = s_reg.ctrl.nine_bit_tx_select;
              s_next.hold_full = 1'b0;
              s_next.phase = AST_START;
              s_next.line = 1'b0; // [RL10]
              s_next.bit_cnt = '0;
            end else begin
              s_next.phase = AST_IDLE;
            end
          end
        end
      endcase
    end

    // Register writes
    if (wr) begin
      unique case (req.paddr)
        AST_ADDR_CTRL: begin
          if (pstrb[0]) begin
            s_next.ctrl.transmit_enable = req.pwdata[AST_CTRL_TX_ON];
            s_next.ctrl.clocked_mode_select = req.pwdata[AST_CTRL_SYNC];
            s_next.ctrl.serial_port_enable = req.pwdata[AST_CTRL_PORT_ON];
            s_next.ctrl.nine_bit_tx_select = req.pwdata[AST_CTRL_NINE];
            s_next.ctrl.tx_polarity_invert = req.pwdata[AST_CTRL_INV];
            s_next.ctrl.ninth_tx_bit = req.pwdata[AST_CTRL_BIT9];
            s_next.ctrl.transmit_irq_enable = req.pwdata[AST_CTRL_TX_IRQ];
            s_next.ctrl.peripheral_irq_enable = req.pwdata[AST_CTRL_PERI_IRQ];
          end
          if (pstrb[1]) begin
            s_next.ctrl.global_irq_enable = req.pwdata[AST_CTRL_ALL_IRQ];
          end
        end
        AST_ADDR_DATA: begin
          // Character plus ninth bit captured together; ignored while stopped
          if (data_wr) begin
            s_next.hold_data = {s_reg.ctrl.ninth_tx_bit, req.pwdata[7:0]}; // [RL17]
            s_next.hold_full = 1'b1;
            s_next.settle = AST_FLAG_SETTLE - 2'h1; // [RL13]
          end
        end
        AST_ADDR_BAUD: begin
          if (pstrb[0]) begin
            s_next.divisor[7:0] = req.pwdata[7:0];
          end
          if (pstrb[1]) begin
            s_next.divisor[15:8] = req.pwdata[15:8];
          end
          if (pstrb[2]) begin
            s_next.wide_div = req.pwdata[AST_BAUD_WIDE]; // [RL3]
          end
        end
        default: begin
          // Status is read only, including the buffer empty flag
          s_next.settle = s_reg.settle; // [RL14]
        end
      endcase
    end

    // Buffer empty flag follows holding state after settling delay;
    // the write edge and the edge after it leave the old value standing
    if (data_wr) begin
      s_next.buf_empty = s_reg.buf_empty; // [RL13]
    end else if (s_reg.settle != '0) begin
      s_next.settle = s_reg.settle - 2'h1; // [RL13]
    end else begin
      s_next.buf_empty = run & ~s_next.hold_full; // [RL12]
    end

    // Shifter empty status
    s_next.shift_empty = (s_next.phase == AST_IDLE); // [RL16]

    // Pins and interrupt request, all registered
    s_next.tx_out = s_next.line ^ s_reg.ctrl.tx_polarity_invert; // [RL11]
    s_next.tx_oe = s_reg.ctrl.serial_port_enable; // [RL7]
    s_next.irq_req = s_next.buf_empty & s_reg.ctrl.transmit_irq_enable &
                     s_reg.ctrl.peripheral_irq_enable &
                     s_reg.ctrl.global_irq_enable; // [RL15]
  end

  // State register with synchronous reset and clock enable
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_reg <= AST_STATE_RESET;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state flops
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign tx_out = s_reg.tx_out;
  assign tx_oe = s_reg.tx_oe;
  assign irq_req = s_reg.irq_req;

endmodule

`default_nettype wire

// File: bench/ast_tx_checker.sv
// Port-level assertions for the serial transmitter
`default_nettype none
module ast_tx_checker
  import ast_pkg::*;
#(
  parameter int DIV_WIDTH = AST_DIV_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_out,
  input wire logic tx_oe,
  input wire logic irq_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic [8:0] ctl_reg;
  logic [3:0] age_reg;
  logic wr, run, mapped;
  // Write strobe, run state, address decode
  assign wr = psel && penable && pready && pwrite;
  assign run = ctl_reg[AST_CTRL_TX_ON] && !ctl_reg[AST_CTRL_SYNC] && ctl_reg[AST_CTRL_PORT_ON];
  assign mapped = paddr inside {AST_ADDR_CTRL, AST_ADDR_DATA, AST_ADDR_STAT, AST_ADDR_BAUD};
  // Control shadow and cycles since a setup write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctl_reg <= '0;
      age_reg <= '0;
    end else begin
      if (wr && paddr == AST_ADDR_CTRL && pstrb[1:0] == 2'h3) begin
        ctl_reg <= pwdata[8:0];
      end
      if (wr && paddr != AST_ADDR_DATA) begin
        age_reg <= '0;
      end else if (age_reg != 4'hf) begin
        age_reg <= age_reg + 4'h1;
      end
    end
  end
  property p_rdy; psel && !penable && ce |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_phase; pready |-> psel && penable; endproperty
  a_phase: assert property (p_phase) else $error("ready outside access");
  property p_err; pready && !mapped |-> pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_ok; pready && mapped |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("mapped refused");
  property p_oe;
    wr && paddr == AST_ADDR_CTRL |=> ##1 tx_oe == ctl_reg[AST_CTRL_PORT_ON];
  endproperty
  a_oe: assert property (p_oe) else $error("driver enable wrong");
  property p_irq; !(&ctl_reg[AST_CTRL_ALL_IRQ:AST_CTRL_TX_IRQ]) |=> !irq_req; endproperty
  a_irq: assert property (p_irq) else $error("irq without enables");
  property p_idle;
    (!run && $stable(ctl_reg)) [*2] |=> tx_out == !ctl_reg[AST_CTRL_INV];
  endproperty
  a_idle: assert property (p_idle) else $error("line not idle");
  property p_hold;
    run && age_reg > 4'h4 && $changed(tx_out) |=> (!$changed(tx_out) || age_reg < 4'h4) [*3];
  endproperty
  a_hold: assert property (p_hold) else $error("bit too short");
  c_irq: cover property ($rose(irq_req));
  c_err: cover property (pready && pslverr);
  c_frame: cover property (run && $fell(tx_out) ##4 !tx_out);
endmodule
bind ast_tx ast_tx_checker #(.DIV_WIDTH(DIV_WIDTH)) u_chk (.core_clk(core_clk), .rst(rst),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_out(tx_out),
  .tx_oe(tx_oe), .irq_req(irq_req));
`default_nettype wire

// File: bench/ast_rx_model.sv
// Behavioural receiving terminal on the serial line
`default_nettype none
module ast_rx_model #(
  parameter int P = 4
) (
  input wire logic core_clk,
  input wire logic line,
  input wire logic inv,
  input wire logic nine,
  input wire logic en,
  output logic [8:0] ch,
  output logic ferr,
  output var int got
);
  timeunit 1ns;
  timeprecision 1ns;
  // Find a start level, then sample each bit mid-period
  initial begin
    got = 0;
    ch = '0;
    ferr = 1'b0;
    forever begin
      @(posedge core_clk);
      if (en && (line ^ inv) == 1'b0) begin
        repeat (P / 2) @(posedge core_clk);
        ch = '0;
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
          repeat (P) @(posedge core_clk);
          ch[i] = line ^ inv;
        end
        repeat (P) @(posedge core_clk);
        ferr = !(line ^ inv);
        got <= got + 1;
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/test_async_serial_transmitter.sv
// Randomised self-checking bench for the serial transmitter
`default_nettype none
module test_async_serial_transmitter;
  import ast_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 4;
  ast_apb_req_t req = '0;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic m_en = 1'b0;
  logic m_inv = 1'b0;
  logic m_nine = 1'b0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata, r;
  logic pready, pslverr, tx_out, tx_oe, irq_req, ferr, e;
  logic [8:0] ch;
  int rx_got, cyc = 0, t0, mismatches = 0, samples_checked = 0;
  // Clock and cycle count
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  ast_tx DUT (.core_clk(core_clk), .rst(rst), .ce(1'b1), .psel(req.psel),
    .penable(req.penable), .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_out(tx_out),
    .tx_oe(tx_oe), .irq_req(irq_req));
  ast_rx_model #(.P(P)) u_rx (.core_clk(core_clk), .line(tx_out), .inv(m_inv),
    .nine(m_nine), .en(m_en), .ch(ch), .ferr(ferr), .got(rx_got));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      tally_and_finish();
    end
    r = prdata;
    e = pslverr;
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic idle(input int c);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    repeat (c) @(posedge core_clk);
  endtask
  task automatic wait_got(input int k);
    int n;
    n = 0;
    while (rx_got < k && n < 500) begin
      idle(1);
      n++;
    end
    if (n >= 500) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  function automatic logic [31:0] ctl(input logic nine, inv, b9, ie);
    ctl = {23'h0, ie, ie, ie, b9, inv, nine, 3'h5};
  endfunction
  function automatic logic [31:0] rx_exp(input logic nine, input logic [8:0] c);
    rx_exp = {nine & c[8], c[7:0], 1'b0};
  endfunction
  function automatic int flen(input logic nine);
    flen = (nine ? 11 : 10) * P;
  endfunction
  // Reset values, refusals, then four framing modes and an abort
  initial begin
    logic [8:0] c[2];
    int k;
    void'($urandom(34105));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    idle(1);
    rd(AST_ADDR_CTRL);
    chk(r, 32'h0);
    rd(AST_ADDR_BAUD);
    chk(r, {16'h0, AST_DIV_RESET});
    apb(1'b1, AST_ADDR_STAT, 32'hffffffff);
    rd(AST_ADDR_STAT);
    chk(r, 32'h6);
    rd(8'h10);
    chk(r, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, 8'h20, 32'h1);
    chk(e, 1'b1);
    apb(1'b1, AST_ADDR_BAUD, 32'(P - 1));
    for (int m = 0; m < 4; m++) begin
      c[0] = (m == 0) ? 9'h000 : 9'($urandom);
      c[1] = (m == 1) ? 9'h1ff : 9'($urandom);
      m_en <= 1'b0;
      apb(1'b1, AST_ADDR_CTRL, ctl(m[0], m[1], 1'b0, m == 3));
      idle(4);
      m_nine <= m[0];
      m_inv <= m[1];
      m_en <= 1'b1;
      k = rx_got;
      chk(irq_req, m == 3);
      rd(AST_ADDR_STAT);
      chk(r[2:0], {!m[1], 2'h3});
      for (int j = 0; j < 2; j++) begin
        apb(1'b1, AST_ADDR_CTRL, ctl(m[0], m[1], c[j][8], m == 3));
        apb(1'b1, AST_ADDR_DATA, {24'h0, c[j][7:0]});
      end
      rd(AST_ADDR_STAT);
      chk(r[0], 1'b1);
      rd(AST_ADDR_STAT);
      chk(r[1:0], 2'h0);
      chk(irq_req, 1'b0);
      for (int j = 0; j < 2; j++) begin
        wait_got(k + j + 1);
        chk({ch, ferr}, rx_exp(m[0], c[j]));
        if (j == 1) chk(cyc - t0, flen(m[0]));
        t0 = cyc;
      end
      k = 0;
      do begin
        rd(AST_ADDR_STAT);
        k++;
      end while (r[AST_STAT_TSEF] !== 1'b1 && k < 100);
      chk(r[1:0], 2'h3);
      if (r[AST_STAT_TSEF] !== 1'b1) tally_and_finish();
      chk(irq_req, m == 3);
    end
    m_en <= 1'b0;
    apb(1'b1, AST_ADDR_DATA, 32'h5a);
    idle(3 * P);
    apb(1'b1, AST_ADDR_CTRL, 32'h14);
    idle(4);
    rd(AST_ADDR_STAT);
    chk(r[2:0], 3'h2);
    apb(1'b1, AST_ADDR_CTRL, 32'h17);
    apb(1'b1, AST_ADDR_DATA, 32'ha5);
    idle(2 * P);
    rd(AST_ADDR_STAT);
    chk(r[2:0], 3'h2);
    apb(1'b1, AST_ADDR_CTRL, 32'h15);
    idle(2);
    rd(AST_ADDR_STAT);
    chk(r[2:0], 3'h3);
    chk(tx_oe, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
